// ===== design/bcr_defines.svh
// address map, field positions and reset values of the board control registers
// Notes on behaviour
// - four host pages, index and data on the first, one byte address on each other
// - first page reached through index then data
// - index zero returns read-only logic revision
// - config control at host index one, processor address
// - status bit shows live configuration busy
// - load direction zero reads, one writes
// - debug control host-only, bit seven zero
// - chain master clear passes emulator chain through
// - processors reset bit holds both processors reset
// - emulation pin levels and pull-up bit
// - read-only emulator present bit
// - boot enable one lets primary boot
// - host led register, one lights led
// - host config, jtag and spare pages blocked until unlock value written; index and data pages always open
// - flash control reachable only by processor
// - flash bit zero shows second host ready
// - flash led field, host write overrides
// - write-allow drives flash protect, resets one
`ifndef BCR_DEFINES_SVH
`define BCR_DEFINES_SVH
`define BCR_LB_DATA 20'hE0000
`define BCR_LB_INDEX 20'hE0008
`define BCR_LB_CFG 20'hE1000
`define BCR_LB_JTAG 20'hE2000
`define BCR_LB_SPARE 20'hE3000
`define BCR_LB_UNLOCK 20'h0040B
`define BCR_IDX_REV 8'h00
`define BCR_IDX_CFG 8'h01
`define BCR_IDX_DBG 8'h02
`define BCR_IDX_LED 8'h03
`define BCR_DSP_CFG 32'h60000001
`define BCR_DSP_FLASH 32'h60000004
`define BCR_UNLOCK_VALUE 8'h5A
`define BCR_CFG_DIR 0
`define BCR_CFG_BUSY 7
`define BCR_DBG_MASTER 0
`define BCR_DBG_RESET 1
`define BCR_DBG_PULLUP 2
`define BCR_DBG_EMU_LO 3
`define BCR_DBG_EMU_HI 4
`define BCR_DBG_PRESENT 5
`define BCR_DBG_BOOT 6
`define BCR_FL_HRDY 0
`define BCR_FL_HINT 1
`define BCR_FL_HCFG 3
`define BCR_FL_LED_LO 4
`define BCR_FL_LED_HI 5
`define BCR_FL_ALLOW 6
`define BCR_FL_READY 7
`define BCR_JT_TCK 0
`define BCR_JT_TMS 1
`define BCR_JT_TDI 2
`define BCR_JT_TDO 0
`define BCR_RST_BYTE 8'h00
`define BCR_RST_ALLOW 1'b1
`endif

// ===== design/bcr_pkg.sv
// types shared by the board control register block
package bcr_pkg;
	typedef logic [7:0] bcr_byte_t;
	typedef enum logic [1:0] {
		BCR_SRC_NONE = 2'b00,
		BCR_SRC_HOST = 2'b01,
		BCR_SRC_DSP = 2'b10
	} bcr_src_t;
endpackage

// ===== design/bcr_top.sv
// board control register block: host local bus and processor memory port
`timescale 1ns/100ps
`include "bcr_defines.svh"
module bcr_top #(
	parameter bcr_pkg::bcr_byte_t LOGIC_REV = 8'h01 // arbitrary value
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [19:0] lb_addr,
	input wire logic lb_rd,
	input wire logic lb_wr,
	input wire logic [7:0] lb_wdata,
	output logic [7:0] lb_rdata_q,
	output logic lb_ack_q,
	input wire logic [31:0] dsp_addr,
	input wire logic dsp_rd,
	input wire logic dsp_wr,
	input wire logic [7:0] dsp_wdata,
	output logic [7:0] dsp_rdata_q,
	output logic dsp_ack_q,
	input wire logic cfg_busy,
	input wire logic [7:0] cfg_din,
	output logic [7:0] cfg_dout_q,
	output logic cfg_strobe_q,
	output logic cfg_rd_q,
	output logic load_direction_q,
	input wire logic emu_tck,
	input wire logic emu_tms,
	input wire logic emu_tdi,
	input wire logic chain_tdo,
	input wire logic emulator_present,
	output logic chain_tck_q,
	output logic chain_tms_q,
	output logic chain_tdi_q,
	output logic emu_tdo_q,
	output logic processors_reset_q,
	output logic primary_boot_enable_q,
	output logic [1:0] emulation_pins_q,
	output logic emu_pullup_enable_q,
	output logic [1:0] local_led_drive_q,
	input wire logic second_host_ready,
	output logic second_host_interrupt_q,
	input wire logic host_configured,
	input wire logic flash_ready,
	output logic flash_write_allow_q,
	output logic host_unlocked_q
);
	bcr_pkg::bcr_byte_t index_q;
	bcr_pkg::bcr_byte_t unlock_q;
	bcr_pkg::bcr_byte_t jtag_q;
	logic chain_master_enable_q;
	logic [7:0] host_rd_d;
	logic [7:0] dsp_rd_d;
	logic host_req;
	logic pg_data, pg_index, pg_cfg, pg_jtag, pg_spare, pg_unlock;
	logic hw_idx_cfg, hw_idx_dbg, hw_idx_led;
	logic dw_cfg, dw_flash;
	logic unlocked;
	bcr_pkg::bcr_src_t led_src;

	// page decode; upper pages answer with zero while locked
	assign host_req = lb_rd | lb_wr;
	assign unlocked = (unlock_q == `BCR_UNLOCK_VALUE);
	assign pg_data = (lb_addr == `BCR_LB_DATA);
	assign pg_index = (lb_addr == `BCR_LB_INDEX);
	assign pg_cfg = (lb_addr == `BCR_LB_CFG) && unlocked;
	assign pg_jtag = (lb_addr == `BCR_LB_JTAG) && unlocked;
	assign pg_spare = (lb_addr == `BCR_LB_SPARE) && unlocked;
	assign pg_unlock = (lb_addr == `BCR_LB_UNLOCK);
	assign hw_idx_cfg = lb_wr && pg_data && (index_q == `BCR_IDX_CFG);
	assign hw_idx_dbg = lb_wr && pg_data && (index_q == `BCR_IDX_DBG);
	assign hw_idx_led = lb_wr && pg_data && (index_q == `BCR_IDX_LED);
	assign dw_cfg = dsp_wr && (dsp_addr == `BCR_DSP_CFG);
	assign dw_flash = dsp_wr && (dsp_addr == `BCR_DSP_FLASH);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			index_q <= `BCR_RST_BYTE;
		end else if (lb_wr && pg_index) begin
			index_q <= lb_wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			unlock_q <= `BCR_RST_BYTE;
		end else if (lb_wr && pg_unlock) begin
			unlock_q <= lb_wdata;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			host_unlocked_q <= 1'b0;
		end else begin
			host_unlocked_q <= unlocked;
		end
	end

	// host writes win a same-cycle clash: the host owns the board in lab use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			load_direction_q <= 1'b0;
		end else if (hw_idx_cfg) begin
			load_direction_q <= lb_wdata[`BCR_CFG_DIR];
		end else if (dw_cfg) begin
			load_direction_q <= dsp_wdata[`BCR_CFG_DIR];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chain_master_enable_q <= 1'b0;
			processors_reset_q <= 1'b0;
			emu_pullup_enable_q <= 1'b0;
			emulation_pins_q <= 2'h0;
			primary_boot_enable_q <= 1'b0;
		end else if (hw_idx_dbg) begin
			chain_master_enable_q <= lb_wdata[`BCR_DBG_MASTER];
			processors_reset_q <= lb_wdata[`BCR_DBG_RESET];
			emu_pullup_enable_q <= lb_wdata[`BCR_DBG_PULLUP];
			emulation_pins_q <= lb_wdata[`BCR_DBG_EMU_HI:`BCR_DBG_EMU_LO];
			primary_boot_enable_q <= lb_wdata[`BCR_DBG_BOOT];
		end
	end

	// one led register, last writer wins; the host overrides on a clash
	always_comb begin
		led_src = bcr_pkg::BCR_SRC_NONE;
		if (hw_idx_led) begin
			led_src = bcr_pkg::BCR_SRC_HOST;
		end else if (dw_flash) begin
			led_src = bcr_pkg::BCR_SRC_DSP;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			local_led_drive_q <= 2'h0;
		end else begin
			unique case (led_src)
				bcr_pkg::BCR_SRC_HOST: local_led_drive_q <= lb_wdata[1:0];
				bcr_pkg::BCR_SRC_DSP: begin
					local_led_drive_q <= dsp_wdata[`BCR_FL_LED_HI:`BCR_FL_LED_LO];
				end
				default: local_led_drive_q <= local_led_drive_q;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flash_write_allow_q <= `BCR_RST_ALLOW;
			second_host_interrupt_q <= 1'b0;
		end else if (dw_flash) begin
			flash_write_allow_q <= dsp_wdata[`BCR_FL_ALLOW];
			second_host_interrupt_q <= dsp_wdata[`BCR_FL_HINT];
		end
	end

	// configuration data page: a write drives a byte out, a read samples the port
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_dout_q <= `BCR_RST_BYTE;
			cfg_strobe_q <= 1'b0;
			cfg_rd_q <= 1'b0;
		end else begin
			cfg_strobe_q <= lb_wr && pg_cfg;
			cfg_rd_q <= lb_rd && pg_cfg;
			if (lb_wr && pg_cfg) begin
				cfg_dout_q <= lb_wdata;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			jtag_q <= `BCR_RST_BYTE;
		end else if (lb_wr && pg_jtag) begin
			jtag_q <= lb_wdata;
		end
	end

	// chain is re-timed by one cycle even in pass-through; fine at tck rates
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			chain_tck_q <= 1'b0;
			chain_tms_q <= 1'b0;
			chain_tdi_q <= 1'b0;
			emu_tdo_q <= 1'b0;
		end else begin
			emu_tdo_q <= chain_tdo;
			if (chain_master_enable_q) begin
				chain_tck_q <= jtag_q[`BCR_JT_TCK];
				chain_tms_q <= jtag_q[`BCR_JT_TMS];
				chain_tdi_q <= jtag_q[`BCR_JT_TDI];
			end else begin
				chain_tck_q <= emu_tck;
				chain_tms_q <= emu_tms;
				chain_tdi_q <= emu_tdi;
			end
		end
	end

	always_comb begin
		host_rd_d = `BCR_RST_BYTE;
		if (pg_index) begin
			host_rd_d = index_q;
		end else if (pg_unlock) begin
			host_rd_d = unlock_q;
		end else if (pg_cfg) begin
			host_rd_d = cfg_din;
		end else if (pg_jtag) begin
			host_rd_d[`BCR_JT_TDO] = chain_tdo;
		end else if (pg_spare) begin
			host_rd_d = `BCR_RST_BYTE;
		end else if (pg_data) begin
			unique case (index_q)
				`BCR_IDX_REV: host_rd_d = LOGIC_REV;
				`BCR_IDX_CFG: begin
					host_rd_d[`BCR_CFG_DIR] = load_direction_q;
					host_rd_d[`BCR_CFG_BUSY] = cfg_busy;
				end
				`BCR_IDX_DBG: begin
					host_rd_d[`BCR_DBG_MASTER] = chain_master_enable_q;
					host_rd_d[`BCR_DBG_RESET] = processors_reset_q;
					host_rd_d[`BCR_DBG_PULLUP] = emu_pullup_enable_q;
					host_rd_d[`BCR_DBG_EMU_HI:`BCR_DBG_EMU_LO] = emulation_pins_q;
					host_rd_d[`BCR_DBG_PRESENT] = emulator_present;
					host_rd_d[`BCR_DBG_BOOT] = primary_boot_enable_q;
				end
				`BCR_IDX_LED: host_rd_d[1:0] = local_led_drive_q;
				default: host_rd_d = `BCR_RST_BYTE;
			endcase
		end
	end

	always_comb begin
		dsp_rd_d = `BCR_RST_BYTE;
		if (dsp_addr == `BCR_DSP_CFG) begin
			dsp_rd_d[`BCR_CFG_DIR] = load_direction_q;
			dsp_rd_d[`BCR_CFG_BUSY] = cfg_busy;
		end else if (dsp_addr == `BCR_DSP_FLASH) begin
			dsp_rd_d[`BCR_FL_HRDY] = second_host_ready;
			dsp_rd_d[`BCR_FL_HINT] = second_host_interrupt_q;
			dsp_rd_d[`BCR_FL_HCFG] = host_configured;
			dsp_rd_d[`BCR_FL_LED_HI:`BCR_FL_LED_LO] = local_led_drive_q;
			dsp_rd_d[`BCR_FL_ALLOW] = flash_write_allow_q;
			dsp_rd_d[`BCR_FL_READY] = flash_ready;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lb_ack_q <= 1'b0;
			lb_rdata_q <= `BCR_RST_BYTE;
		end else begin
			lb_ack_q <= host_req;
			lb_rdata_q <= lb_rd ? host_rd_d : `BCR_RST_BYTE;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dsp_ack_q <= 1'b0;
			dsp_rdata_q <= `BCR_RST_BYTE;
		end else begin
			dsp_ack_q <= dsp_rd | dsp_wr;
			dsp_rdata_q <= dsp_rd ? dsp_rd_d : `BCR_RST_BYTE;
		end
	end

	sequence s_sel_dbg;
		lb_wr && pg_index && (lb_wdata == `BCR_IDX_DBG);
	endsequence
	sequence s_wr_data;
		lb_wr && pg_data;
	endsequence

	// the idle cycle between index and data keeps the selected index in place
	chk_index_then_data: assert property (@(posedge clk) disable iff (sys_rst)
		s_sel_dbg ##1 !(lb_wr && pg_index) ##1 s_wr_data
		|=> processors_reset_q == $past(lb_wdata[`BCR_DBG_RESET]))
		else $error("indirect debug write not applied");
	chk_rev_read: assert property (@(posedge clk) disable iff (sys_rst)
		lb_rd && pg_data && index_q == `BCR_IDX_REV |=> lb_rdata_q == LOGIC_REV && lb_ack_q)
		else $error("revision read wrong");
	chk_busy_live: assert property (@(posedge clk) disable iff (sys_rst)
		dsp_rd && dsp_addr == `BCR_DSP_CFG |=> dsp_rdata_q[`BCR_CFG_BUSY] == $past(cfg_busy))
		else $error("busy bit not live");
	chk_dbg_bit7: assert property (@(posedge clk) disable iff (sys_rst)
		lb_rd && pg_data && index_q == `BCR_IDX_DBG |=> !lb_rdata_q[7])
		else $error("debug bit 7 not zero");
	chk_chain_pass: assert property (@(posedge clk) disable iff (sys_rst)
		!chain_master_enable_q ##1 (!chain_master_enable_q)[*2]
		|-> {chain_tdi_q, chain_tms_q, chain_tck_q} == $past({emu_tdi, emu_tms, emu_tck}))
		else $error("chain not passed through");
	chk_chain_drive: assert property (@(posedge clk) disable iff (sys_rst)
		chain_master_enable_q |=> {chain_tdi_q, chain_tms_q, chain_tck_q}
		== $past({jtag_q[`BCR_JT_TDI], jtag_q[`BCR_JT_TMS], jtag_q[`BCR_JT_TCK]}))
		else $error("chain not driven from jtag register");
	chk_lock_block: assert property (@(posedge clk) disable iff (sys_rst)
		!unlocked && lb_wr && lb_addr == `BCR_LB_CFG |=> !cfg_strobe_q)
		else $error("locked config write passed");
	chk_flash_host: assert property (@(posedge clk) disable iff (sys_rst)
		!dw_flash |=> $stable(flash_write_allow_q) && $stable(second_host_interrupt_q))
		else $error("flash control changed without processor write");
	chk_led_override: assert property (@(posedge clk) disable iff (sys_rst)
		hw_idx_led |=> local_led_drive_q == $past(lb_wdata[1:0]))
		else $error("host led write did not override");
	chk_led_dsp: assert property (@(posedge clk) disable iff (sys_rst)
		dw_flash && !hw_idx_led
		|=> local_led_drive_q == $past(dsp_wdata[`BCR_FL_LED_HI:`BCR_FL_LED_LO]))
		else $error("processor led write not applied");
	chk_hready_read: assert property (@(posedge clk) disable iff (sys_rst)
		dsp_rd && dsp_addr == `BCR_DSP_FLASH |=> dsp_rdata_q[0] == $past(second_host_ready))
		else $error("host ready bit wrong");
endmodule // bcr_top

// ===== dv/bcr_master_model.sv
// bus master model for the host local bus and the processor memory port
`timescale 1ns/100ps
module bcr_master_model (
	input wire logic clk,
	output logic [19:0] lb_addr,
	output logic lb_rd,
	output logic lb_wr,
	output logic [7:0] lb_wdata,
	input wire logic [7:0] lb_rdata_q,
	input wire logic lb_ack_q,
	output logic [31:0] dsp_addr,
	output logic dsp_rd,
	output logic dsp_wr,
	output logic [7:0] dsp_wdata,
	input wire logic [7:0] dsp_rdata_q,
	input wire logic dsp_ack_q
);
	initial begin
		{lb_addr, lb_rd, lb_wr, lb_wdata} = '0;
		{dsp_addr, dsp_rd, dsp_wr, dsp_wdata} = '0;
	end
	// one byte access; callers write the index before the data
	task automatic acc(input bit p, input bit w, input logic [31:0] a, input logic [7:0] d,
		output logic [7:0] r, output bit ok);
		@(posedge clk);
		if (p) begin
			dsp_addr <= a;
			dsp_wdata <= d;
			dsp_rd <= !w;
			dsp_wr <= w;
		end else begin
			lb_addr <= a[19:0];
			lb_wdata <= d;
			lb_rd <= !w;
			lb_wr <= w;
		end
		@(posedge clk);
		{lb_rd, lb_wr, dsp_rd, dsp_wr} <= 4'h0;
		// released lines do not keep the last value
		lb_addr <= ~lb_addr;
		lb_wdata <= ~lb_wdata;
		dsp_addr <= ~dsp_addr;
		dsp_wdata <= ~dsp_wdata;
		ok = 1'b0;
		for (int i = 0; i < 4 && !ok; i++) begin
			#1;
			if ((p ? dsp_ack_q : lb_ack_q) === 1'b1) begin
				ok = 1'b1;
				r = p ? dsp_rdata_q : lb_rdata_q;
			end else
				@(posedge clk);
		end
	endtask
endmodule // bcr_master_model

// ===== dv/tb_bcr_top.sv
// self-checking bench for the board control register block
`timescale 1ns/100ps
`include "bcr_defines.svh"
module tb_bcr_top;
	localparam bcr_pkg::bcr_byte_t REV = 8'h3C; // arbitrary value
	logic clk, sys_rst, cfg_busy, emu_tck, emulator_present;
	logic emu_tms, emu_tdi, chain_tdo;
	logic second_host_ready, host_configured, flash_ready;
	logic [7:0] cfg_din, rd;
	bit ok;
	int bad_count, num_checks;
	wire [19:0] lb_addr;
	wire [31:0] dsp_addr;
	wire [7:0] lb_wdata, lb_rdata_q, dsp_wdata, dsp_rdata_q, cfg_dout_q;
	wire lb_rd, lb_wr, lb_ack_q, dsp_rd, dsp_wr, dsp_ack_q;
	wire [1:0] emulation_pins_q, local_led_drive_q;
	wire cfg_strobe_q, load_direction_q, chain_tck_q, processors_reset_q, primary_boot_enable_q;
	wire emu_pullup_enable_q, second_host_interrupt_q, flash_write_allow_q, host_unlocked_q;
	wire cfg_rd_q, chain_tms_q, chain_tdi_q, emu_tdo_q;
	wire [7:0] outs = {processors_reset_q, primary_boot_enable_q, emulation_pins_q,
		emu_pullup_enable_q, local_led_drive_q, second_host_interrupt_q};
	bcr_top #(.LOGIC_REV(REV)) bcr_top_inst (.clk, .sys_rst, .lb_addr, .lb_rd, .lb_wr, .lb_wdata,
		.lb_rdata_q, .lb_ack_q, .dsp_addr, .dsp_rd, .dsp_wr, .dsp_wdata, .dsp_rdata_q, .dsp_ack_q,
		.cfg_busy, .cfg_din, .cfg_dout_q, .cfg_strobe_q, .cfg_rd_q, .load_direction_q, .emu_tck,
		.emu_tms, .emu_tdi, .chain_tdo, .emulator_present, .chain_tck_q,
		.chain_tms_q, .chain_tdi_q, .emu_tdo_q, .processors_reset_q, .primary_boot_enable_q,
		.emulation_pins_q, .emu_pullup_enable_q, .local_led_drive_q, .second_host_ready,
		.second_host_interrupt_q, .host_configured, .flash_ready, .flash_write_allow_q,
		.host_unlocked_q);
	bcr_master_model bcr_master_model_inst (.clk, .lb_addr, .lb_rd, .lb_wr, .lb_wdata,
		.lb_rdata_q, .lb_ack_q, .dsp_addr, .dsp_rd, .dsp_wr, .dsp_wdata, .dsp_rdata_q, .dsp_ack_q);
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic go(input bit p, input bit w, input logic [31:0] a, input logic [7:0] d);
		bcr_master_model_inst.acc(p, w, a, d, rd, ok);
		if (!ok) begin
			bad_count++;
			$display("mismatch ack expected 1 seen 0");
			give_verdict();
		end
	endtask
	task automatic hw(input logic [7:0] i, input logic [7:0] d);
		go(0, 1, `BCR_LB_INDEX, i);
		go(0, 1, `BCR_LB_DATA, d);
	endtask
	task automatic hr(input logic [7:0] i);
		go(0, 1, `BCR_LB_INDEX, i);
		go(0, 0, `BCR_LB_DATA, 8'h00);
	endtask
	task automatic t_reset();
		chk("allow", flash_write_allow_q, 8'h01);
		chk("outs", outs, 8'h00);
		hr(`BCR_IDX_REV);
		chk("rev", rd, REV);
		hr(`BCR_IDX_DBG);
		chk("dbg", rd, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_debug();
		hw(`BCR_IDX_DBG, 8'hFF);
		chk("outs", outs, 8'hF8);
		hr(`BCR_IDX_DBG);
		chk("dbg", rd, 8'h5F);
		@(posedge clk) emulator_present <= 1'b1;
		hr(`BCR_IDX_DBG);
		chk("present", rd, 8'h7F);
		hw(`BCR_IDX_DBG, 8'h00);
		chk("release", processors_reset_q, 8'h00);
		@(posedge clk) {emu_tck, emu_tms, emu_tdi} <= 3'h7;
		@(posedge clk);
		#1;
		chk("pass", {chain_tdi_q, chain_tms_q, chain_tck_q}, 8'h07);
		$display("test debug done");
	endtask
	task automatic t_cfg();
		hw(`BCR_IDX_CFG, 8'h01);
		chk("dir", load_direction_q, 8'h01);
		@(posedge clk) cfg_busy <= 1'b1;
		go(1, 0, `BCR_DSP_CFG, 8'h00);
		chk("cfgdsp", rd, 8'h81);
		go(1, 1, `BCR_DSP_CFG, 8'h00);
		chk("dir", load_direction_q, 8'h00);
		hr(`BCR_IDX_CFG);
		chk("cfghost", rd, 8'h80);
		$display("test config done");
	endtask
	task automatic t_lock();
		go(0, 1, `BCR_LB_CFG, 8'hA5);
		chk("lockstb", cfg_strobe_q, 8'h00);
		go(0, 0, `BCR_LB_CFG, 8'h00);
		chk("lockrd", rd, 8'h00);
		chk("lockrdstb", cfg_rd_q, 8'h00);
		go(0, 1, `BCR_LB_UNLOCK, `BCR_UNLOCK_VALUE);
		// the unlocked flag is registered from the unlock register, one cycle later
		@(posedge clk);
		#1;
		chk("unlocked", host_unlocked_q, 8'h01);
		go(0, 1, `BCR_LB_CFG, 8'hA5);
		chk("cfgout", {cfg_strobe_q, cfg_dout_q[6:0]}, 8'hA5);
		go(0, 0, `BCR_LB_CFG, 8'h00);
		chk("cfgin", rd, 8'hC3);
		chk("cfgrd", cfg_rd_q, 8'h01);
		hw(`BCR_IDX_DBG, 8'h01);
		@(posedge clk) {emu_tck, emu_tms, emu_tdi} <= 3'h0;
		go(0, 1, `BCR_LB_JTAG, 8'h07);
		@(posedge clk);
		#1;
		chk("master", {chain_tdi_q, chain_tms_q, chain_tck_q}, 8'h07);
		@(posedge clk) chain_tdo <= 1'b1;
		go(0, 0, `BCR_LB_JTAG, 8'h00);
		chk("tdo", {rd[0], emu_tdo_q}, 8'h03);
		$display("test lock done");
	endtask
	task automatic t_flash();
		@(posedge clk) {second_host_ready, host_configured, flash_ready} <= 3'h7;
		go(1, 1, `BCR_DSP_FLASH, 8'h32);
		chk("allow", flash_write_allow_q, 8'h00);
		chk("hint", second_host_interrupt_q, 8'h01);
		chk("led", local_led_drive_q, 8'h03);
		go(1, 0, `BCR_DSP_FLASH, 8'h00);
		chk("flash", rd, 8'hBB);
		hw(`BCR_IDX_LED, 8'h01);
		chk("hostled", local_led_drive_q, 8'h01);
		hr(8'h04);
		chk("noflash", rd, 8'h00);
		$display("test flash done");
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		sys_rst = 1'b1;
		{cfg_busy, emu_tck, emulator_present} = 3'h0;
		{emu_tms, emu_tdi, chain_tdo} = 3'h0;
		{second_host_ready, host_configured, flash_ready} = 3'h0;
		cfg_din = 8'hC3;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		t_reset();
		t_debug();
		t_cfg();
		t_lock();
		t_flash();
		give_verdict();
	end
endmodule // tb_bcr_top
